// ===== dv/ssfs_chk.sv
`timescale 1ns/1ns
module ssfs_chk #(
  parameter int unsigned INIT_HOLD = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic select_low,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic hard_init_low
);
  // ************************************************************
  // Helper counters
  // ************************************************************
  logic [5:0] rise_cnt_ff;
  logic sclk_old_ff;
  int unsigned low_cnt_ff;

  // Rising serial clock edges seen inside the current frame.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rise_cnt_ff <= 6'h0;
      sclk_old_ff <= 1'b0;
    end else begin
      sclk_old_ff <= sclk;
      if (select_low) begin
        rise_cnt_ff <= 6'h0;
      end else if (sclk && !sclk_old_ff) begin
        rise_cnt_ff <= rise_cnt_ff + 6'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt_ff <= 0;
    end else if (!hard_init_low) begin
      low_cnt_ff <= low_cnt_ff + 1;
    end else begin
      low_cnt_ff <= 0;
    end
  end

  // ************************************************************
  // Link properties
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_quiet_sclk;
    !sclk[*8];
  endsequence

  sequence s_high_phase;
    sclk[*8] ##1 !sclk;
  endsequence

  a_released_idle: assert property (select_low[*8] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_drives_selected: assert property ((!select_low)[*6] |-> miso_oe)
    else $error("miso not driven while selected");
  a_quiet_open: assert property ($fell(select_low) |-> s_quiet_sclk)
    else $error("sclk active near select fall");
  a_quiet_close: assert property ($rose(select_low) |->
    !$past(sclk, 1) && !$past(sclk, 6))
    else $error("sclk active near select rise");
  a_mosi_on_low: assert property (
    (!select_low && $changed(mosi)) |-> !sclk)
    else $error("mosi changed while sclk high");
  a_miso_on_low: assert property (
    (miso_oe && $changed(miso)) |-> !sclk)
    else $error("miso changed while sclk high");
  a_high_phase: assert property ($rose(sclk) |-> s_high_phase)
    else $error("sclk high phase not eight cycles");
  a_frame_bits: assert property (
    $rose(select_low) |-> rise_cnt_ff == 6'h20)
    else $error("frame without 32 clocks");
  // A frame is lead-in, 64 half periods and a quiet tail.
  a_frame_closes: assert property (
    $fell(select_low) |-> ##[530:540] $rose(select_low))
    else $error("select not returned high at frame end");
  a_init_long: assert property (
    $rose(hard_init_low) |-> low_cnt_ff >= INIT_HOLD)
    else $error("hard init released too early");
endmodule // ssfs_chk

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ssfs_pkg::*;
  localparam int unsigned HOLD = 50;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NSRC-1:0][DW-1:0] sense_in;
  logic alarm_in = 1'b0;
  logic [15:0] stored [NSRC];
  logic [31:0] sh_mosi, sh_miso, mosi_word, miso_word, prev_ans, q;
  logic [1:0] ka;
  int num_errors = 0;
  int samples_checked = 0;

  always #4 core_clk = ~core_clk;

  ssfs_if link ();
  ssfs_host #(.INIT_HOLD(HOLD)) u_ssfs_host (.core_clk(core_clk),
    .rst(rst), .link(link), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  ssfs_device #(.ODR_PERIOD(20)) u_ssfs_device (.core_clk(core_clk),
    .rst(rst), .link(link), .sense_in(sense_in), .alarm_in(alarm_in));
  ssfs_chk #(.INIT_HOLD(HOLD)) u_ssfs_chk (.core_clk(core_clk), .rst(rst),
    .sclk(link.sclk), .select_low(link.select_low), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe),
    .hard_init_low(link.hard_init_low));

  // ************************************************************
  // Wire monitor: both data lines taken at the serial rising edge
  // ************************************************************
  always @(posedge link.sclk) begin
    if (!link.select_low) begin
      sh_mosi <= {sh_mosi[30:0], link.mosi};
      sh_miso <= {sh_miso[30:0], link.miso};
    end
  end

  always @(posedge link.select_low) begin
    mosi_word <= sh_mosi;
    miso_word <= sh_miso;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic logic [3:0] tb_crc(input logic [27:0] d);
    logic [3:0] c;
    c = CRC_INIT;
    for (int i = 27; i >= 0; i--) c = {c[2:0], c[3] ^ d[i]};
    return c;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge itself,
  // before the slave's own update lands, and the request stays up
  // through that edge. Only the watchdog ends a stalled command.
  task automatic av_xfer(input logic wr, input logic [1:0] a,
                         input logic [31:0] d, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic frame(input logic [3:0] sel, input logic sync);
    logic [31:0] cmd, ans, st, rsp;
    logic [15:0] dat;
    logic ok;
    int n;
    cmd[31:4] = {16'h0, MODE_DATA, 1'b0, sel, sync, 3'b000};
    cmd[3:0] = tb_crc(cmd[31:4]);
    av_xfer(1'b1, REG_CMD, {27'h0, sync, sel}, rsp);
    ok = !sel[0] || sel >= SEL_TEMP1;
    case (sel)
      SEL_TEMP1: dat = stored[6];
      SEL_TEMP2: dat = stored[7];
      SEL_TDIFF: dat = stored[6] - stored[7];
      SEL_FIXED: dat = FIXED_WORD;
      default: dat = stored[sel[3:1]];
    endcase
    if (ok) ka = ka + 2'h1;
    ans[31:4] = ok ? {dat, alarm_in ? FLAG_ALARM : FLAG_OK, RSP_B13_12,
                      sel, sync, 1'b0, ka} : 28'h0;
    ans[3:0] = tb_crc(ans[31:4]);
    n = 0;
    do begin
      av_xfer(1'b0, REG_STAT, 32'h0, st);
      n++;
    end while (st[ST_BUSY] !== 1'b0 && n < 300);
    check("busy_done", {31'h0, st[ST_BUSY]}, 32'h0);
    av_xfer(1'b0, REG_RESP, 32'h0, rsp);
    check("answer", rsp, prev_ans);
    check("mosi_word", mosi_word, cmd);
    check("miso_word", miso_word, rsp);
    if (prev_ans !== 32'h0) begin
      check("crc_ok", {31'h0, st[ST_CRC_OK]}, 32'h1);
    end
    prev_ans = ans;
  endtask

  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    final_report();
  end

  initial begin
    prev_ans = 32'h0;
    ka = 2'h0;
    repeat (5) @(posedge core_clk);
    for (int i = 0; i < NSRC; i++) begin
      sense_in[i] <= 16'(32'h1111 * i + 32'h8005);
    end
    rst <= 1'b0;
    av_xfer(1'b0, REG_STAT, 32'h0, q);
    check("init_active", {31'h0, q[ST_INIT]}, 32'h1);
    frame(SEL_FIXED, 1'b1);
    for (int i = 0; i < NSRC; i++) stored[i] = sense_in[i];
    // Every selector code, reserved ones included; the live samples
    // change after the first read so a refresh without sync shows up.
    for (int s = 0; s < 16; s++) begin
      frame(4'(s), 1'b0);
      if (s == 0) begin
        @(posedge core_clk);
        for (int i = 0; i < NSRC; i++) sense_in[i] <= ~sense_in[i];
      end
    end
    @(posedge core_clk);
    alarm_in <= 1'b1;
    frame(SEL_FIXED, 1'b0);
    @(posedge core_clk);
    alarm_in <= 1'b0;
    frame(SEL_FIXED, 1'b1);
    for (int i = 0; i < NSRC; i++) stored[i] = sense_in[i];
    frame(4'h0, 1'b0);
    frame(SEL_TDIFF, 1'b0);
    av_xfer(1'b1, REG_INIT, 32'h0, q);
    av_xfer(1'b0, REG_STAT, 32'h0, q);
    check("init_restart", {31'h0, q[ST_INIT]}, 32'h1);
    ka = 2'h0;
    prev_ans = 32'h0;
    for (int i = 0; i < NSRC; i++) stored[i] = 16'h0;
    frame(4'h0, 1'b0);
    frame(SEL_FIXED, 1'b0);
    frame(SEL_FIXED, 1'b0);
    final_report();
  end
endmodule // tb_top

// ===== rtl/ssfs_device.sv
`timescale 1ns/1ns
module ssfs_device #(
  parameter int unsigned ODR_PERIOD = ssfs_pkg::ODR_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  ssfs_if.dev link,
  input wire logic [ssfs_pkg::NSRC-1:0][ssfs_pkg::DW-1:0] sense_in,
  input wire logic alarm_in
);
  import ssfs_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  localparam int unsigned SY_INIT = 0;
  localparam int unsigned SY_SCLK = 1;
  localparam int unsigned SY_SEL = 2;
  localparam int unsigned SY_MOSI = 3;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic old_sclk;
    logic old_sel;
    logic [ODR_W-1:0] odr_cnt;
    logic [NSRC-1:0][DW-1:0] live;
    logic [NSRC-1:0][DW-1:0] held;
    logic armed;
    logic [1:0] keep_alive_count;
    logic [FRAME_BITS-1:0] resp;
    logic oe;
  } ssfs_dev_st_t;

  // Select idles high, so the edge detector starts from high as well.
  localparam ssfs_dev_st_t ST_RST = '{
    sy1: 4'hf,
    sy2: 4'hf,
    old_sel: 1'b1,
    default: '0
  };

  ssfs_dev_st_t st_ff;
  ssfs_dev_st_t nxt_st;

  // ************************************************************
  // Link edges, seen through two synchronising stages
  // ************************************************************
  logic selected;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic odr_tick;
  logic sh_dout;
  logic [FRAME_BITS-1:0] sh_rx;
  logic [CNT_W-1:0] sh_cnt;

  // Slave only: every edge comes from the host's clock and select.
  assign selected = !st_ff.sy2[SY_SEL];
  assign sel_fall = st_ff.old_sel && !st_ff.sy2[SY_SEL];
  assign sel_rise = !st_ff.old_sel && st_ff.sy2[SY_SEL];
  assign sclk_rise = selected && !st_ff.old_sclk
    && st_ff.sy2[SY_SCLK];
  assign sclk_fall = selected && st_ff.old_sclk
    && !st_ff.sy2[SY_SCLK];
  assign odr_tick = st_ff.odr_cnt == ODR_W'(ODR_PERIOD - 1);

  ssfs_shreg u_shreg (
    .core_clk(core_clk),
    .rst(rst),
    .load(sel_fall),
    .load_word(st_ff.resp),
    .rise(sclk_rise),
    .fall(sclk_fall),
    .din(st_ff.sy2[SY_MOSI]),
    .dout(sh_dout),
    .rx_word(sh_rx),
    .bit_count(sh_cnt)
  );

  // ************************************************************
  // Command decode and answer build
  // ************************************************************
  logic [3:0] sel_code;
  logic sel_ok;
  logic cmd_ok;
  logic [DW-1:0] pick;
  logic [1:0] ka_next;
  logic [FRAME_BITS-1:0] word;

  assign sel_code = sh_rx[SEL_HI:SEL_LO];
  assign ka_next = st_ff.keep_alive_count + 2'h1;

  always_comb begin
    sel_ok = 1'b1;
    pick = '0;
    unique case (sel_code)
      SEL_TEMP1: pick = st_ff.held[SRC_TEMP1];
      SEL_TEMP2: pick = st_ff.held[SRC_TEMP2];
      SEL_TDIFF: pick = st_ff.held[SRC_TEMP1] - st_ff.held[SRC_TEMP2];
      SEL_FIXED: pick = FIXED_WORD;
      default: begin
        // Odd codes below the temperature block are reserved.
        sel_ok = !sel_code[0];
        pick = st_ff.held[sel_code[3:1]];
      end
    endcase
  end

  // A frame counts only with 32 clocks, a good check code, the
  // data monitor pattern and an unreserved selector; anything else leaves sync and keep-alive alone and queues an empty answer.
  assign cmd_ok = (sh_cnt == CNT_W'(FRAME_BITS))
    && (sh_rx[3:0] == ssfs_crc4(sh_rx[FRAME_BITS-1:4]))
    && (sh_rx[MODE_HI:MODE_LO] == MODE_DATA)
    && sel_ok;

  always_comb begin
    word = '0;
    if (cmd_ok) begin
      word[FRAME_BITS-1:DW] = pick;
      word[15:14] = alarm_in ? FLAG_ALARM : FLAG_OK;
      word[13:12] = RSP_B13_12;
      word[SEL_HI:SEL_LO] = sel_code;
      word[SYNC_POS] = sh_rx[SYNC_POS];
      word[5:4] = ka_next;
    end
    word[3:0] = ssfs_crc4(word[FRAME_BITS-1:4]);
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sy1 = {link.mosi, link.select_low, link.sclk,
      link.hard_init_low};
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.old_sclk = st_ff.sy2[SY_SCLK];
    nxt_st.old_sel = st_ff.sy2[SY_SEL];

    // Sampling runs on its own timebase, whatever the serial rate.
    if (odr_tick) begin
      nxt_st.odr_cnt = '0;
      nxt_st.live = sense_in;
    end else begin
      nxt_st.odr_cnt = st_ff.odr_cnt + 1'b1;
    end

    if (sel_fall) begin
      nxt_st.oe = 1'b1;
      // All data types are frozen together, so one read sequence
      // after a sync request sees a consistent set.
      if (st_ff.armed) begin
        nxt_st.held = st_ff.live;
      end
    end

    if (sel_rise) begin
      nxt_st.oe = 1'b0;
      nxt_st.resp = word;
      if (cmd_ok) begin
        nxt_st.armed = sh_rx[SYNC_POS];
        nxt_st.keep_alive_count = ka_next;
      end
    end

    // Hard init clears all state here except the synchroniser chain; the shift register keeps its contents.
    if (!st_ff.sy2[SY_INIT]) begin
      nxt_st = ST_RST;
      nxt_st.sy1 = {link.mosi, link.select_low, link.sclk,
        link.hard_init_low};
      nxt_st.sy2 = st_ff.sy1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************
  // The data pin is released whenever select is high so other
  // slaves on the shared line are undisturbed.
  assign link.miso = sh_dout;
  assign link.miso_oe = st_ff.oe;
endmodule // ssfs_device

// ===== rtl/ssfs_host.sv
`timescale 1ns/1ns
module ssfs_host #(
  parameter int unsigned INIT_HOLD = ssfs_pkg::INIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  ssfs_if.host link,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import ssfs_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_RUN = 3'b010,
    HS_TAIL = 3'b011,
    HS_GAP = 3'b100
  } ssfs_hst_t;

  typedef struct packed {
    logic miso1;
    logic miso2;
    ssfs_hst_t hs;
    logic [DIV_W-1:0] div;
    logic sclk;
    logic select_low;
    logic busy;
    logic [3:0] sel;
    logic sync;
    logic [FRAME_BITS-1:0] resp;
    logic crc_ok;
    logic [INIT_W-1:0] init_cnt;
    logic init_low;
    logic waitreq;
    logic [31:0] rdata;
  } ssfs_host_st_t;

  localparam ssfs_host_st_t ST_RST = '{
    hs: HS_IDLE,
    select_low: 1'b1,
    init_cnt: INIT_W'(INIT_HOLD),
    waitreq: 1'b1,
    default: '0
  };

  ssfs_host_st_t st_ff;
  ssfs_host_st_t nxt_st;

  logic half_done;
  logic rise_p;
  logic fall_p;
  logic cmd_wr;
  logic can_go;
  logic accept;
  logic start;
  logic [FRAME_BITS-1:0] cmd_word;
  logic sh_dout;
  logic [FRAME_BITS-1:0] sh_rx;
  logic [CNT_W-1:0] sh_cnt;

  // Half period rounds up, so the clock stays at or below 8 MHz.
  assign half_done = st_ff.div == DIV_W'(SCLK_HALF_CYC - 1);
  assign rise_p = st_ff.hs == HS_RUN && half_done && !st_ff.sclk;
  assign fall_p = st_ff.hs == HS_RUN && half_done && st_ff.sclk;
  assign cmd_wr = avs_write && avs_address == REG_CMD;
  assign can_go = st_ff.hs == HS_IDLE && st_ff.init_low;
  // A command write waits while a frame or hard init is running.
  assign accept = (avs_read || avs_write) && st_ff.waitreq
    && (!cmd_wr || can_go);
  assign start = accept && cmd_wr;

  always_comb begin
    cmd_word = '0;
    cmd_word[MODE_HI:MODE_LO] = MODE_DATA;
    cmd_word[SEL_HI:SEL_LO] = avs_writedata[3:0];
    cmd_word[SYNC_POS] = avs_writedata[CMD_SYNC];
    cmd_word[3:0] = ssfs_crc4(cmd_word[FRAME_BITS-1:4]);
  end

  ssfs_shreg u_shreg (
    .core_clk(core_clk),
    .rst(rst),
    .load(start),
    .load_word(cmd_word),
    .rise(rise_p),
    .fall(fall_p),
    .din(st_ff.miso2),
    .dout(sh_dout),
    .rx_word(sh_rx),
    .bit_count(sh_cnt)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.miso1 = link.miso;
    nxt_st.miso2 = st_ff.miso1;
    nxt_st.div = st_ff.div + 1'b1;
    unique case (st_ff.hs)
      HS_IDLE: begin
        nxt_st.div = '0;
        if (start) begin
          nxt_st.hs = HS_LEAD;
          nxt_st.select_low = 1'b0;
          nxt_st.busy = 1'b1;
          nxt_st.sel = avs_writedata[3:0];
          nxt_st.sync = avs_writedata[CMD_SYNC];
        end
      end
      HS_LEAD: begin
        // Two quiet halves let the slave load its first bit.
        if (st_ff.div == DIV_W'(2 * SCLK_HALF_CYC - 1)) begin
          nxt_st.hs = HS_RUN;
          nxt_st.div = '0;
        end
      end
      HS_RUN: begin
        if (half_done) begin
          nxt_st.div = '0;
          nxt_st.sclk = !st_ff.sclk;
          if (fall_p && sh_cnt == CNT_W'(FRAME_BITS)) begin
            nxt_st.hs = HS_TAIL;
          end
        end
      end
      HS_TAIL: begin
        if (half_done) begin
          nxt_st.hs = HS_GAP;
          nxt_st.div = '0;
          nxt_st.select_low = 1'b1;
          nxt_st.resp = sh_rx;
          nxt_st.crc_ok = sh_rx[3:0]
            == ssfs_crc4(sh_rx[FRAME_BITS-1:4]);
        end
      end
      HS_GAP: begin
        if (half_done) begin
          nxt_st.hs = HS_IDLE;
          nxt_st.busy = 1'b0;
        end
      end
      default: begin
        nxt_st.hs = HS_IDLE;
      end
    endcase

    if (st_ff.init_cnt != '0) begin
      nxt_st.init_cnt = st_ff.init_cnt - 1'b1;
    end
    nxt_st.init_low = st_ff.init_cnt == '0;

    nxt_st.waitreq = 1'b1;
    if (accept) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          REG_CMD: nxt_st.rdata = {27'h0, st_ff.sync, st_ff.sel};
          REG_STAT: nxt_st.rdata = {29'h0, st_ff.crc_ok,
            !st_ff.init_low, st_ff.busy};
          REG_RESP: nxt_st.rdata = st_ff.resp;
          REG_INIT: nxt_st.rdata = '0;
        endcase
      end
      if (avs_write && avs_address == REG_INIT) begin
        nxt_st.init_cnt = INIT_W'(INIT_HOLD);
        nxt_st.init_low = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.sclk = st_ff.sclk;
  assign link.select_low = st_ff.select_low;
  assign link.mosi = sh_dout;
  assign link.hard_init_low = st_ff.init_low;
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
endmodule // ssfs_host

// ===== rtl/ssfs_if.sv
`timescale 1ns/1ns
interface ssfs_if;
  logic sclk;
  logic select_low;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic hard_init_low;
  modport dev (
    input sclk,
    input select_low,
    input mosi,
    input hard_init_low,
    output miso,
    output miso_oe
  );
  modport host (
    output sclk,
    output select_low,
    output mosi,
    output hard_init_low,
    input miso
  );
endinterface

// ===== rtl/ssfs_pkg.sv
package ssfs_pkg;
  // ************************************************************
  // What this block does
  // - Device is slave only; host supplies clock.
  // - Host frames each transfer with select low.
  // - Data output released while select is high.
  // - Frames shift most significant bit first.
  // - Receivers sample data on rising clock edge.
  // - Transmitters change data on falling clock edge.
  // - Serial clock never exceeds 8 MHz.
  // - Every frame holds exactly 32 clock cycles.
  // - Clock idles low around both select edges.
  // - Hard init held low at least 10 ms.
  // - Answer to a command comes next frame.
  // - Internal registers update at select rising edge; the sync sample snapshot loads at the falling edge.
  // - Samples refresh at 8000 per second.
  // - Data read command carries 101 in 15:13.
  // - Selector code sits in command bits 11:8.
  // - Answer bits 31:16 carry signed sample.
  // - Selector picks axis, temperature or fixed word.
  // - Bits 15:14 read 10 normally, 01 alarmed.
  // - Sync bit set captures all data next frame.
  // - Two-bit keep-alive count increments each read.
  // - Low four bits carry CRC, init 0xA.
  // ************************************************************

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CORE_HZ = 125_000_000;
  localparam int unsigned SCLK_MAX_HZ = 8_000_000;
  localparam int unsigned SCLK_HALF_CYC =
    (CORE_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int unsigned DIV_W = 5;
  localparam int unsigned ODR_HZ = 8000;
  localparam int unsigned ODR_CYC = CORE_HZ / ODR_HZ;
  localparam int unsigned ODR_W = 14;
  localparam int unsigned INIT_MS = 10;
  localparam int unsigned INIT_CYC = (CORE_HZ / 1000) * INIT_MS;
  localparam int unsigned INIT_W = 21;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned DW = 16;
  localparam int unsigned NSRC = 8;
  localparam int unsigned MODE_HI = 15;
  localparam int unsigned MODE_LO = 13;
  localparam logic [2:0] MODE_DATA = 3'h5;
  localparam int unsigned SEL_HI = 11;
  localparam int unsigned SEL_LO = 8;
  localparam int unsigned SYNC_POS = 7;
  localparam logic [1:0] RSP_B13_12 = 2'h2;
  localparam logic [1:0] FLAG_OK = 2'h2;
  localparam logic [1:0] FLAG_ALARM = 2'h1;
  localparam logic [3:0] CRC_INIT = 4'ha;
  localparam logic [3:0] CRC_POLY = 4'h1;
  localparam logic [3:0] SEL_TEMP1 = 4'hc;
  localparam logic [3:0] SEL_TEMP2 = 4'hd;
  localparam logic [3:0] SEL_TDIFF = 4'he;
  localparam logic [3:0] SEL_FIXED = 4'hf;
  localparam logic [2:0] SRC_TEMP1 = 3'h6;
  localparam logic [2:0] SRC_TEMP2 = 3'h7;
  localparam logic [15:0] FIXED_WORD = 16'haa55;

  // ************************************************************
  // Host register map (word index) and fields
  // ************************************************************
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_RESP = 2'h2;
  localparam logic [1:0] REG_INIT = 2'h3;
  localparam int unsigned CMD_SYNC = 4;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_INIT = 1;
  localparam int unsigned ST_CRC_OK = 2;

  // Check code over the upper 28 bits, shifted in MSB first.
  function automatic logic [3:0] ssfs_crc4(input logic [27:0] d);
    logic [3:0] c;
    c = CRC_INIT;
    for (int i = 27; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ({4{c[3] ^ d[i]}} & CRC_POLY);
    end
    return c;
  endfunction
endpackage

// ===== rtl/ssfs_shreg.sv
`timescale 1ns/1ns
module ssfs_shreg (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [ssfs_pkg::FRAME_BITS-1:0] load_word,
  input wire logic rise,
  input wire logic fall,
  input wire logic din,
  output logic dout,
  output logic [ssfs_pkg::FRAME_BITS-1:0] rx_word,
  output logic [ssfs_pkg::CNT_W-1:0] bit_count
);
  import ssfs_pkg::*;

  typedef struct packed {
    logic [FRAME_BITS-1:0] tx;
    logic [FRAME_BITS-1:0] rx;
    logic [CNT_W-1:0] cnt;
  } ssfs_sh_st_t;

  ssfs_sh_st_t st_ff;
  ssfs_sh_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.tx = load_word;
      nxt_st.rx = '0;
      nxt_st.cnt = '0;
    end else begin
      if (rise) begin
        nxt_st.rx = {st_ff.rx[FRAME_BITS-2:0], din};
        // Saturates so an overlong frame never looks like a good one.
        if (st_ff.cnt != '1) begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      if (fall) begin
        nxt_st.tx = {st_ff.tx[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.tx[FRAME_BITS-1];
  assign rx_word = st_ff.rx;
  assign bit_count = st_ff.cnt;
endmodule // ssfs_shreg
